// ### common/mcc_pkg.sv
package mcc_pkg;

    // register byte addresses
    localparam logic [7:0] MCC_ADDR_CSR      = 8'h2C;
    localparam logic [7:0] MCC_ADDR_BEEP     = 8'h2D;
    localparam logic [7:0] MCC_ADDR_IRQ_STAT = 8'h2E;
    localparam logic [7:0] MCC_ADDR_IRQ_MASK = 8'h2F;

    // reset values
    localparam logic [7:0] MCC_CSR_RESET  = 8'h00;
    localparam logic [1:0] MCC_TONE_RESET = 2'h0;
    localparam logic [1:0] MCC_IRQ_RESET  = 2'h0;

    // field positions of the control/status register
    localparam int MCC_CSR_CLK_OUT_BIT = 7;
    localparam int MCC_CSR_PRESC_LSB   = 5;
    localparam int MCC_CSR_SLOW_BIT    = 4;
    localparam int MCC_CSR_TB_LSB      = 2;
    localparam int MCC_CSR_OIE_BIT     = 1;
    localparam int MCC_CSR_FLAG_BIT    = 0;

    // bits of the interrupt status and mask registers
    localparam int MCC_IRQ_TIMEOUT_BIT = 0;
    localparam int MCC_IRQ_WAKE_BIT    = 1;

    // time-base periods in oscillator cycles
    localparam int MCC_TB_PERIOD_0 = 16000;
    localparam int MCC_TB_PERIOD_1 = 32000;
    localparam int MCC_TB_PERIOD_2 = 80000;
    localparam int MCC_TB_PERIOD_3 = 200000;

    // tone half periods in oscillator cycles
    localparam int MCC_TONE_HALF_1 = 2000;
    localparam int MCC_TONE_HALF_2 = 4000;
    localparam int MCC_TONE_HALF_3 = 8000;

    // counter widths
    localparam int MCC_TB_W   = 18;
    localparam int MCC_TONE_W = 13;
    localparam int MCC_DIV_W  = 4;

    // software view of the control/status register
    typedef struct packed {
        logic       clock_out_select;
        logic [1:0] slow_prescaler_field;
        logic       slow_select;
        logic [1:0] time_base_field;
        logic       osc_irq_enable;
        logic       timeout_flag;
    } mcc_csr_t;

    typedef enum logic [1:0] {
        MCC_RUN   = 2'b00,
        MCC_WAIT  = 2'b01,
        MCC_AHALT = 2'b10,
        MCC_HALT  = 2'b11
    } mcc_mode_t;

endpackage

// ### hdl/mcc_clock_ctrl.sv
`timescale 1ns/1ns
// Contract
// (RULE_01) time-base periods 16000/32000/80000/200000 cycles
// (RULE_02) new period select applies at period end
// (RULE_03) period end sets flag; csr read clears
// (RULE_04) irq needs enable and cpu unmasked
// (RULE_05) halt with enable enters active-halt
// (RULE_06) time-base irq wakes wait, active-halt only
// (RULE_07) full halt freezes counter and registers
// (RULE_08) active-halt counts, registers frozen; wait normal
// (RULE_09) slow mode divides by 2/4/8/16
// (RULE_10) slow select off means undivided cpu clock
// (RULE_11) clock-out select routes cpu clock to pin; pin toggles per cpu enable, so half the rate
// (RULE_12) clock out inactive in active-halt
// (RULE_13) tone field: off, 2k, 1k, 500Hz, 50%
// (RULE_14) tone keeps running in active-halt
// (RULE_15) software keeps beep upper bits zero
// (RULE_16) software avoids bit set/clear on csr
// (RULE_17) tone from counter toggling each half period
// (RULE_18) timeout on read cycle keeps flag set
module mcc_clock_ctrl #(
    parameter int TB_PERIOD_0 = mcc_pkg::MCC_TB_PERIOD_0,
    parameter int TB_PERIOD_1 = mcc_pkg::MCC_TB_PERIOD_1,
    parameter int TB_PERIOD_2 = mcc_pkg::MCC_TB_PERIOD_2,
    parameter int TB_PERIOD_3 = mcc_pkg::MCC_TB_PERIOD_3,
    parameter int TONE_HALF_1 = mcc_pkg::MCC_TONE_HALF_1,
    parameter int TONE_HALF_2 = mcc_pkg::MCC_TONE_HALF_2,
    parameter int TONE_HALF_3 = mcc_pkg::MCC_TONE_HALF_3
) (
    input  wire logic       i_ref_clk,
    input  wire logic       i_reset,
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    input  wire logic       i_cpu_irq_mask,
    input  wire logic       i_halt_req,
    input  wire logic       i_wait_req,
    input  wire logic       i_wake_irq,
    output logic      [7:0] o_rdata_q,
    output logic            o_cpu_clk_en_q,
    output logic            o_clk_out_q,
    output logic            o_clk_out_oe_q,
    output logic            o_tone_q,
    output logic            o_tone_oe_q,
    output logic            o_timebase_irq_q,
    output logic            o_irq_q,
    output logic      [1:0] o_mode_q
);

    localparam int TBW = mcc_pkg::MCC_TB_W;
    localparam int TNW = mcc_pkg::MCC_TONE_W;
    localparam int DVW = mcc_pkg::MCC_DIV_W;

    mcc_pkg::mcc_csr_t  csr_q;
    mcc_pkg::mcc_mode_t mode_q;
    mcc_pkg::mcc_mode_t mode_d;
    logic [1:0]         tone_sel_q;
    logic [1:0]         irq_stat_q;
    logic [1:0]         irq_mask_q;
    logic [1:0]         tb_active_q;
    logic [TBW-1:0]     tb_cnt_q;
    logic [TNW-1:0]     tone_cnt_q;
    logic [DVW-1:0]     div_cnt_q;

    logic tb_end;
    logic tb_req;
    logic cpu_en;
    logic regs_live;
    logic wr_csr;
    logic rd_csr;
    logic wr_beep;
    logic wr_stat;
    logic wr_mask;
    logic wake_evt;
    logic tone_wrap;

    // last count of a time-base period
    function automatic logic [TBW-1:0] tb_last(input logic [1:0] sel);
        logic [TBW-1:0] v;
        v = '0;
        case (sel)
            2'h0: v = TBW'(TB_PERIOD_0 - 1);
            2'h1: v = TBW'(TB_PERIOD_1 - 1);
            2'h2: v = TBW'(TB_PERIOD_2 - 1);
            default: v = TBW'(TB_PERIOD_3 - 1);
        endcase
        return v;
    endfunction

    // last count of a tone half period
    function automatic logic [TNW-1:0] tone_last(input logic [1:0] sel);
        logic [TNW-1:0] v;
        v = '0;
        case (sel)
            2'h1: v = TNW'(TONE_HALF_1 - 1);
            2'h2: v = TNW'(TONE_HALF_2 - 1);
            default: v = TNW'(TONE_HALF_3 - 1);
        endcase
        return v;
    endfunction

    // last count of the slow-mode divider: 1, 3, 7, 15
    function automatic logic [DVW-1:0] div_last(input logic [1:0] sel);
        logic [DVW-1:0] v;
        v = '0;
        case (sel)
            2'h0: v = 4'h1;
            2'h1: v = 4'h3;
            2'h2: v = 4'h7;
            default: v = 4'hF;
        endcase
        return v;
    endfunction

    // registers only move while the cpu runs (run or wait)
    assign regs_live = (mode_q == mcc_pkg::MCC_RUN) ||
                       (mode_q == mcc_pkg::MCC_WAIT); // [RULE_07] [RULE_08]

    // address decode of the register port
    always_comb begin
        wr_csr  = 1'b0;
        wr_beep = 1'b0;
        wr_stat = 1'b0;
        wr_mask = 1'b0;
        rd_csr  = 1'b0;
        if (i_addr == mcc_pkg::MCC_ADDR_CSR) begin
            wr_csr = i_wr & regs_live;
            rd_csr = i_rd & regs_live;
        end else if (i_addr == mcc_pkg::MCC_ADDR_BEEP) begin
            wr_beep = i_wr & regs_live;
        end else if (i_addr == mcc_pkg::MCC_ADDR_IRQ_STAT) begin
            wr_stat = i_wr & regs_live;
        end else if (i_addr == mcc_pkg::MCC_ADDR_IRQ_MASK) begin
            wr_mask = i_wr & regs_live;
        end
    end

    // period end of the running selection
    assign tb_end = (mode_q != mcc_pkg::MCC_HALT) &&
                    (tb_cnt_q == tb_last(tb_active_q)); // [RULE_01]

    // time-base interrupt request
    assign tb_req = csr_q.timeout_flag & csr_q.osc_irq_enable &
                    ~i_cpu_irq_mask; // [RULE_04]

    // cpu clock enable before halt gating
    assign cpu_en = ~csr_q.slow_select ||
                    (div_cnt_q == div_last(csr_q.slow_prescaler_field));

    // time-base counter; frozen only by full halt
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            tb_cnt_q <= '0;
        end else if (mode_q == mcc_pkg::MCC_HALT) begin
            tb_cnt_q <= tb_cnt_q; // [RULE_07]
        end else if (tb_end) begin
            tb_cnt_q <= '0; // [RULE_01]
        end else begin
            tb_cnt_q <= tb_cnt_q + 1'b1; // [RULE_08]
        end
    end

    // selection latched at period end, so no time shift
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            tb_active_q <= 2'h0;
        end else if (tb_end) begin
            tb_active_q <= csr_q.time_base_field; // [RULE_02]
        end
    end

    // control/status register; flag is read-only to software
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            csr_q <= mcc_pkg::MCC_CSR_RESET;
        end else begin
            if (wr_csr) begin
                csr_q.clock_out_select <=
                    i_wdata[mcc_pkg::MCC_CSR_CLK_OUT_BIT]; // [RULE_11]
                csr_q.slow_prescaler_field <=
                    i_wdata[mcc_pkg::MCC_CSR_PRESC_LSB +: 2]; // [RULE_09]
                csr_q.slow_select <=
                    i_wdata[mcc_pkg::MCC_CSR_SLOW_BIT]; // [RULE_10]
                csr_q.time_base_field <=
                    i_wdata[mcc_pkg::MCC_CSR_TB_LSB +: 2];
                csr_q.osc_irq_enable <=
                    i_wdata[mcc_pkg::MCC_CSR_OIE_BIT];
            end
            // set beats the read clear in the same cycle
            if (tb_end) begin
                csr_q.timeout_flag <= 1'b1; // [RULE_03] [RULE_18]
            end else if (rd_csr) begin
                csr_q.timeout_flag <= 1'b0; // [RULE_03]
            end
        end
    end

    // beep control; upper bits are not stored and read zero
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            tone_sel_q <= mcc_pkg::MCC_TONE_RESET;
        end else if (wr_beep) begin
            tone_sel_q <= i_wdata[1:0]; // [RULE_13]
        end
    end

    // power mode sequencing
    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            mcc_pkg::MCC_RUN: begin
                if (i_halt_req) begin
                    mode_d = csr_q.osc_irq_enable ? mcc_pkg::MCC_AHALT
                                                  : mcc_pkg::MCC_HALT; // [RULE_05]
                end else if (i_wait_req) begin
                    mode_d = mcc_pkg::MCC_WAIT;
                end
            end
            mcc_pkg::MCC_WAIT: begin
                if (tb_req || i_wake_irq) begin
                    mode_d = mcc_pkg::MCC_RUN; // [RULE_06]
                end
            end
            mcc_pkg::MCC_AHALT: begin
                if (tb_req || i_wake_irq) begin
                    mode_d = mcc_pkg::MCC_RUN; // [RULE_06]
                end
            end
            default: begin
                // time-base cannot fire here: counter is frozen
                if (i_wake_irq) begin
                    mode_d = mcc_pkg::MCC_RUN; // [RULE_06] [RULE_07]
                end
            end
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            mode_q <= mcc_pkg::MCC_RUN;
        end else begin
            mode_q <= mode_d;
        end
    end

    assign wake_evt = (mode_q != mcc_pkg::MCC_RUN) &&
                      (mode_d == mcc_pkg::MCC_RUN);

    // slow-mode divider; stopped with the cpu in either halt
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            div_cnt_q <= '0;
        end else if (~regs_live || ~csr_q.slow_select || cpu_en) begin
            div_cnt_q <= '0;
        end else begin
            div_cnt_q <= div_cnt_q + 1'b1; // [RULE_09]
        end
    end

    // cpu clock as enable pulse, one per divided period
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_cpu_clk_en_q <= 1'b0;
        end else begin
            o_cpu_clk_en_q <= cpu_en & regs_live; // [RULE_10]
        end
    end

    // clock out pin: toggles per cpu enable, so half the rate
    // since a flop cannot repeat the reference clock itself
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_clk_out_q    <= 1'b0;
            o_clk_out_oe_q <= 1'b0;
        end else begin
            o_clk_out_oe_q <= csr_q.clock_out_select &&
                              (mode_q != mcc_pkg::MCC_AHALT); // [RULE_12]
            if (~csr_q.clock_out_select ||
                mode_q == mcc_pkg::MCC_AHALT) begin
                o_clk_out_q <= 1'b0; // [RULE_12]
            end else if (cpu_en && regs_live) begin
                o_clk_out_q <= ~o_clk_out_q; // [RULE_11]
            end
        end
    end

    assign tone_wrap = (tone_cnt_q == tone_last(tone_sel_q));

    // tone divider; runs in active-halt, frozen in full halt
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            tone_cnt_q  <= '0;
            o_tone_q    <= 1'b0;
            o_tone_oe_q <= 1'b0;
        end else if (tone_sel_q == 2'h0) begin
            tone_cnt_q  <= '0;
            o_tone_q    <= 1'b0;
            o_tone_oe_q <= 1'b0; // [RULE_13]
        end else if (mode_q != mcc_pkg::MCC_HALT) begin
            o_tone_oe_q <= 1'b1; // [RULE_14]
            if (tone_wrap) begin
                tone_cnt_q <= '0;
                o_tone_q   <= ~o_tone_q; // [RULE_17]
            end else begin
                tone_cnt_q <= tone_cnt_q + 1'b1; // [RULE_17]
            end
        end
    end

    // sticky event bits, write one to clear, set wins
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            irq_stat_q <= mcc_pkg::MCC_IRQ_RESET;
        end else begin
            for (int b = 0; b < 2; b++) begin
                if (wr_stat && i_wdata[b]) begin
                    irq_stat_q[b] <= 1'b0;
                end
            end
            if (tb_end) begin
                irq_stat_q[mcc_pkg::MCC_IRQ_TIMEOUT_BIT] <= 1'b1; // [RULE_18]
            end
            if (wake_evt) begin
                irq_stat_q[mcc_pkg::MCC_IRQ_WAKE_BIT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            irq_mask_q <= mcc_pkg::MCC_IRQ_RESET;
        end else if (wr_mask) begin
            irq_mask_q <= i_wdata[1:0];
        end
    end

    // interrupt outputs
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_timebase_irq_q <= 1'b0;
            o_irq_q          <= 1'b0;
        end else begin
            o_timebase_irq_q <= tb_req; // [RULE_04]
            o_irq_q          <= |(irq_stat_q & irq_mask_q);
        end
    end

    // read data for one cycle; unmapped reads as zero
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_rdata_q <= 8'h00;
        end else if (~i_rd) begin
            o_rdata_q <= 8'h00;
        end else if (i_addr == mcc_pkg::MCC_ADDR_CSR) begin
            o_rdata_q <= csr_q;
        end else if (i_addr == mcc_pkg::MCC_ADDR_BEEP) begin
            o_rdata_q <= {6'h00, tone_sel_q};
        end else if (i_addr == mcc_pkg::MCC_ADDR_IRQ_STAT) begin
            o_rdata_q <= {6'h00, irq_stat_q};
        end else if (i_addr == mcc_pkg::MCC_ADDR_IRQ_MASK) begin
            o_rdata_q <= {6'h00, irq_mask_q};
        end else begin
            o_rdata_q <= 8'h00;
        end
    end

    // mode visible for power management
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_mode_q <= 2'b00;
        end else begin
            o_mode_q <= mode_d;
        end
    end

endmodule

// ### tb/mcc_pin_model.sv
`timescale 1ns/1ns
// far-side listener on the tone and clock-out pins; hears driven pins only
module mcc_pin_model (
    input  wire logic        i_ref_clk,
    input  wire logic        i_tone,
    input  wire logic        i_tone_oe,
    input  wire logic        i_clk_out,
    input  wire logic        i_clk_out_oe,
    output logic      [15:0] o_half_len,
    output logic      [15:0] o_tone_edges,
    output logic      [15:0] o_clk_edges
);
    logic [15:0] run_len = 16'h0000;
    logic [15:0] half_len = 16'h0000;
    logic [15:0] tone_edges = 16'h0000;
    logic [15:0] clk_edges = 16'h0000;
    logic        tone_last = 1'b0;
    logic        clk_last = 1'b0;
    // one process owns each count; ports only mirror them
    assign o_half_len = half_len;
    assign o_tone_edges = tone_edges;
    assign o_clk_edges = clk_edges;
    // last tone half period in reference cycles, plus edge counts
    always @(posedge i_ref_clk) begin
        tone_last <= i_tone;
        clk_last <= i_clk_out;
        run_len <= run_len + 16'h0001;
        if (i_tone_oe && i_tone !== tone_last) begin
            half_len <= run_len;
            run_len <= 16'h0001;
            tone_edges <= tone_edges + 16'h0001;
        end
        if (i_clk_out_oe && i_clk_out !== clk_last) begin
            clk_edges <= clk_edges + 16'h0001;
        end
    end
endmodule

// ### tb/mcc_asserts.sv
`timescale 1ns/1ns
// port-level checks; the tone check assumes half periods of 4 or more
module mcc_asserts (
    input wire logic       i_ref_clk,
    input wire logic       i_reset,
    input wire logic       i_halt_req,
    input wire logic       i_wake_irq,
    input wire logic       i_cpu_irq_mask,
    input wire logic       o_cpu_clk_en_q,
    input wire logic       o_clk_out_oe_q,
    input wire logic       o_tone_q,
    input wire logic       o_tone_oe_q,
    input wire logic       o_timebase_irq_q,
    input wire logic [1:0] o_mode_q
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);
    // halt modes judged only when held two samples, so output lag is moot
    a_irq_unmask: assert property (
        o_timebase_irq_q |-> !$past(i_cpu_irq_mask)
    ) else $error("timebase irq while cpu mask active");
    a_halt_entry: assert property (
        o_mode_q == mcc_pkg::MCC_RUN && i_halt_req |=> o_mode_q[1]
    ) else $error("halt request not taken");
    a_halt_stays: assert property (
        o_mode_q == mcc_pkg::MCC_HALT && !i_wake_irq
        |=> o_mode_q == mcc_pkg::MCC_HALT
    ) else $error("full halt left without wake");
    a_no_clkout_ahalt: assert property (
        o_mode_q == mcc_pkg::MCC_AHALT && $past(o_mode_q) == o_mode_q
        |-> !o_clk_out_oe_q
    ) else $error("clock out driven in active halt");
    a_cpu_idle_halt: assert property (
        o_mode_q[1] && $past(o_mode_q[1]) |-> !o_cpu_clk_en_q
    ) else $error("cpu enable in halt");
    a_tone_frozen: assert property (
        o_mode_q == mcc_pkg::MCC_HALT && $past(o_mode_q) == o_mode_q
        |-> $stable(o_tone_q)
    ) else $error("tone moved in full halt");
    a_tone_off_low: assert property (
        !o_tone_oe_q |-> !o_tone_q
    ) else $error("tone pin high while off");
    a_tone_half_min: assert property (
        $changed(o_tone_q) && o_tone_oe_q && $past(o_tone_oe_q)
        |=> ($stable(o_tone_q) || !o_tone_oe_q) [*3]
    ) else $error("tone half period too short");
endmodule

bind mcc_clock_ctrl mcc_asserts u_mcc_asserts (
    .i_ref_clk        (i_ref_clk),
    .i_reset          (i_reset),
    .i_halt_req       (i_halt_req),
    .i_wake_irq       (i_wake_irq),
    .i_cpu_irq_mask   (i_cpu_irq_mask),
    .o_cpu_clk_en_q   (o_cpu_clk_en_q),
    .o_clk_out_oe_q   (o_clk_out_oe_q),
    .o_tone_q         (o_tone_q),
    .o_tone_oe_q      (o_tone_oe_q),
    .o_timebase_irq_q (o_timebase_irq_q),
    .o_mode_q         (o_mode_q)
);

// ### tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    // short counts keep the run brief
    localparam int P0 = 16, P1 = 32, P2 = 80, P3 = 200;
    localparam int H1 = 4, H2 = 8, H3 = 16;
    localparam logic [7:0] CSR = mcc_pkg::MCC_ADDR_CSR;
    localparam logic [7:0] BEEP = mcc_pkg::MCC_ADDR_BEEP;
    localparam logic [7:0] STAT = mcc_pkg::MCC_ADDR_IRQ_STAT;
    int per [4] = '{P0, P1, P2, P3};
    int half [4] = '{0, H1, H2, H3};
    logic        clk, rst, bwr, brd, imask, halt, waitr, wake;
    logic [7:0]  addr, wdata, rdata, d;
    logic        cpu_en, cko, cko_oe, tone, tone_oe, tb_irq, irq;
    logic [1:0]  mode;
    logic [15:0] hlen, tedges, cedges;
    int          failures = 0, checked = 0, cyc = 0;
    int          r0, r1, rp, old, n, e0, s;

    mcc_clock_ctrl #(.TB_PERIOD_0(P0), .TB_PERIOD_1(P1), .TB_PERIOD_2(P2),
        .TB_PERIOD_3(P3), .TONE_HALF_1(H1), .TONE_HALF_2(H2),
        .TONE_HALF_3(H3)) dut (
        .i_ref_clk(clk), .i_reset(rst), .i_addr(addr), .i_wdata(wdata),
        .i_wr(bwr), .i_rd(brd), .i_cpu_irq_mask(imask),
        .i_halt_req(halt), .i_wait_req(waitr), .i_wake_irq(wake),
        .o_rdata_q(rdata), .o_cpu_clk_en_q(cpu_en), .o_clk_out_q(cko),
        .o_clk_out_oe_q(cko_oe), .o_tone_q(tone), .o_tone_oe_q(tone_oe),
        .o_timebase_irq_q(tb_irq), .o_irq_q(irq), .o_mode_q(mode));
    mcc_pin_model u_pins (.i_ref_clk(clk), .i_tone(tone),
        .i_tone_oe(tone_oe), .i_clk_out(cko), .i_clk_out_oe(cko_oe),
        .o_half_len(hlen), .o_tone_edges(tedges), .o_clk_edges(cedges));

    // 125 MHz reference and a cycle count for period measurement
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;

    task automatic check(input string nm, input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    // whole-byte accesses only: a read clears the timeout flag
    task automatic reg_wr(input logic [7:0] a, v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        bwr <= 1'b1;
        @(posedge clk);
        bwr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        brd <= 1'b1;
        @(posedge clk);
        brd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic rd_chk(input logic [7:0] a, e, m);
        reg_rd(a);
        check("register", d & m, e);
    endtask
    task automatic mode_req(input logic h, w);
        @(posedge clk);
        halt <= h;
        waitr <= w;
        @(posedge clk);
        halt <= 1'b0;
        waitr <= 1'b0;
        @(negedge clk);
    endtask
    task automatic wait_mode(input logic [1:0] m, input int lim);
        int k;
        k = 0;
        while (mode !== m && k < lim) begin
            @(negedge clk);
            k++;
        end
        check("mode", mode, m);
    endtask
    // clear the status bit, then time the next period end
    task automatic next_rise(output int t);
        int k;
        k = 0;
        reg_wr(STAT, 8'h01);
        while (irq !== 1'b0 && k < 600) begin
            @(negedge clk);
            k++;
        end
        while (irq !== 1'b1 && k < 600) begin
            @(negedge clk);
            k++;
        end
        t = cyc;
        check("period end", k < 600, 1'b1);
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // watchdog: the tests need about 2600 cycles
    initial begin
        #400000;
        failures++;
        test_done;
    end

    initial begin
        {rst, bwr, brd, imask, halt, waitr, wake} = 7'h40;
        addr = 8'h00;
        wdata = 8'h00;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd_chk(CSR, 8'h00, 8'hFE);
        rd_chk(BEEP, 8'h00, 8'hFF);
        rd_chk(8'h2F, 8'h00, 8'hFF);
        reg_wr(8'h30, 8'hFF);
        rd_chk(8'h30, 8'h00, 8'hFF);
        reg_wr(BEEP, 8'h03);
        rd_chk(BEEP, 8'h03, 8'hFF);
        reg_wr(CSR, 8'hEE);
        rd_chk(CSR, 8'hEE, 8'hFE);
        reg_wr(CSR, 8'h00);
        reg_wr(BEEP, 8'h00);
        repeat (20) @(negedge clk);
        check("masked irq", irq, 1'b0);
        reg_wr(8'h2F, 8'h01);
        $display("test registers done");
        next_rise(rp);
        next_rise(rp);
        old = 0;
        for (int i = 1; i < 5; i++) begin
            s = i % 4;
            reg_wr(CSR, 8'(s << 2));
            next_rise(r0);
            check("old period", r0 - rp, per[old]);
            next_rise(r1);
            check("new period", r1 - r0, per[s]);
            rp = r1;
            old = s;
        end
        next_rise(r0);
        reg_rd(CSR);
        check("flag set", d[0], 1'b1);
        reg_rd(CSR);
        check("flag cleared", d[0], 1'b0);
        // land a csr read on the very edge that ends the next period
        next_rise(r0);
        repeat (P0 - 3) @(posedge clk);
        reg_rd(CSR);
        reg_rd(CSR);
        check("flag kept", d[0], 1'b1);
        $display("test time base done");
        @(posedge clk) imask <= 1'b1;
        reg_wr(CSR, 8'h02);
        n = 0;
        repeat (40) @(negedge clk) n += tb_irq;
        check("irq under mask", n, 0);
        @(posedge clk) imask <= 1'b0;
        repeat (3) @(negedge clk);
        check("irq unmasked", tb_irq, 1'b1);
        $display("test interrupt done");
        reg_wr(BEEP, 8'h01);
        reg_wr(CSR, 8'h8E);
        next_rise(r0);
        next_rise(r0);
        reg_rd(CSR);
        mode_req(1'b1, 1'b0);
        check("ahalt", mode, mcc_pkg::MCC_AHALT);
        e0 = tedges;
        repeat (2) @(negedge clk);
        check("clock out oe", cko_oe, 1'b0);
        wait_mode(mcc_pkg::MCC_RUN, 300);
        check("tone in ahalt", tedges - e0 >= 40, 1'b1);
        rd_chk(STAT, 8'h02, 8'h02);
        reg_wr(CSR, 8'h8C);
        mode_req(1'b1, 1'b0);
        check("halt", mode, mcc_pkg::MCC_HALT);
        // a toggle launched on the entry edge is heard one edge later
        reg_wr(BEEP, 8'h02);
        e0 = tedges;
        repeat (250) @(negedge clk);
        check("still halt", mode, mcc_pkg::MCC_HALT);
        check("tone frozen", tedges, e0);
        @(posedge clk) wake <= 1'b1;
        wait_mode(mcc_pkg::MCC_RUN, 10);
        @(posedge clk) wake <= 1'b0;
        rd_chk(BEEP, 8'h01, 8'hFF);
        reg_wr(CSR, 8'h0E);
        next_rise(r0);
        reg_rd(CSR);
        mode_req(1'b0, 1'b1);
        check("wait", mode, mcc_pkg::MCC_WAIT);
        n = 0;
        repeat (8) @(negedge clk) n += cpu_en;
        check("cpu enable in wait", n, 8);
        wait_mode(mcc_pkg::MCC_RUN, 300);
        $display("test power modes done");
        for (int p = 0; p < 5; p++) begin
            reg_wr(CSR, (p < 4) ? 8'(8'h90 | (p << 5)) : 8'h80);
            repeat (20) @(negedge clk);
            n = 0;
            e0 = cedges;
            repeat (64) @(negedge clk) n += cpu_en;
            check("cpu rate", n, (p < 4) ? 64 >> (p + 1) : 64);
            check("clock out edges", cedges - e0, n);
        end
        reg_wr(CSR, 8'h00);
        repeat (3) @(negedge clk);
        check("clock out free", {cko_oe, cko}, 2'h0);
        $display("test cpu clock done");
        for (int t = 1; t < 4; t++) begin
            reg_wr(BEEP, 8'h00);
            reg_wr(BEEP, 8'(t));
            repeat (7 * half[t]) @(negedge clk);
            check("tone half", hlen, half[t]);
            check("tone oe", tone_oe, 1'b1);
        end
        reg_wr(BEEP, 8'h00);
        repeat (3) @(negedge clk);
        check("tone off", {tone_oe, tone}, 2'h0);
        $display("test tone done");
        test_done;
    end
endmodule
